// File: shared/phase_shed_pkg.sv
package phase_shed_pkg;

    // ----------------------------------------------------------------
    // command decode and paging
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_SLOPE_CONFIG = 8'hde;
    localparam logic [7:0] PAGE_CH_A = 8'h00;
    localparam logic [7:0] PAGE_CH_B = 8'h01;
    localparam int NUM_PAGES = 2;
    localparam int REG_WIDTH = 16;

    // ----------------------------------------------------------------
    // field positions of the configuration word
    // ----------------------------------------------------------------
    localparam int UNUSED_HI = 15;
    localparam int UNUSED_LO = 10;
    localparam int DROP_OFS_HI = 9;
    localparam int DROP_OFS_LO = 8;
    localparam int SHED_EN_BIT = 7;
    localparam int XSLOPE_HI = 6;
    localparam int XSLOPE_LO = 5;
    localparam int TWO_PH_BIT = 4;
    localparam int ONE_PH_BIT = 3;
    localparam int BASE_HI = 2;
    localparam int BASE_LO = 0;

    // ----------------------------------------------------------------
    // slope amplitudes in millivolts
    // ----------------------------------------------------------------
    localparam logic [8:0] SLOPE_STEP_MV = 9'h028;
    localparam logic [8:0] SLOPE_TWO_PH_MV = 9'h078;
    localparam logic [8:0] SLOPE_ONE_PH_MV = 9'h050;

    // ----------------------------------------------------------------
    // drop threshold arithmetic in amperes
    // ----------------------------------------------------------------
    localparam logic [5:0] PEAK_BASE_A = 6'h0c;
    localparam logic [5:0] PEAK_STEP_A = 6'h02;
    localparam logic [5:0] DROP_OFS_STEP_A = 6'h02;
    localparam logic [5:0] DROP_OFS_BASE_A = 6'h02;
    localparam logic [1:0] PHASES_ONE = 2'h1;
    localparam logic [1:0] PHASES_TWO = 2'h2;
    localparam logic [1:0] PHASES_THREE = 2'h3;

    // base slope code to amplitude, 40 mV per step from 40 mV
    function automatic logic [8:0] slope_mv(input logic [2:0] code);
        slope_mv = 9'(SLOPE_STEP_MV * (9'(code) + 9'h001));
    endfunction : slope_mv

    // peak-efficiency current selected by the companion register
    function automatic logic [5:0] peak_amps(input logic [1:0] sel);
        peak_amps = 6'(PEAK_BASE_A + PEAK_STEP_A * 6'(sel));
    endfunction : peak_amps

    // twice the peak current plus an offset of -2, 0, +2 or +4 A
    function automatic logic [5:0] drop_threshold(input logic [1:0] sel,
                                                  input logic [1:0] ofs);
        drop_threshold = 6'(6'(peak_amps(sel) << 1) + 6'(DROP_OFS_STEP_A * 6'(ofs)) - DROP_OFS_BASE_A);
    endfunction : drop_threshold

endpackage : phase_shed_pkg

// File: design/channel_slope_shed.sv
`timescale 1ns/1ps

module channel_slope_shed
    import phase_shed_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [15:0] i_cfg,
    input wire logic [1:0] i_peak_sel,
    input wire logic [7:0] i_avg_current,
    input wire logic [1:0] i_phase_count,
    input wire logic i_fast_transient,
    output logic o_shed_enable,
    output logic [5:0] o_drop_threshold,
    output logic o_drop_request,
    output logic [8:0] o_slope_mv
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic shed_en_r, shed_en_nxt;
    logic [5:0] thresh_r, thresh_nxt;
    logic drop_r, drop_nxt;
    logic [8:0] slope_r, slope_nxt;

    // decode of the stored word; bits 15:10 are never looked at
    always_comb begin
        logic [1:0] xcode;
        xcode = i_cfg[XSLOPE_HI:XSLOPE_LO];
        shed_en_nxt = i_cfg[SHED_EN_BIT];
        thresh_nxt = drop_threshold(i_peak_sel, i_cfg[DROP_OFS_HI:DROP_OFS_LO]);
        // drop when average per-phase current falls to the threshold
        drop_nxt = i_cfg[SHED_EN_BIT] && (i_phase_count == PHASES_THREE)
            && (i_avg_current <= {2'h0, thresh_nxt});
        // overrides fall back to the base slope when their code is zero
        slope_nxt = slope_mv(i_cfg[BASE_HI:BASE_LO]);
        if (i_fast_transient && xcode != 2'h0) begin
            slope_nxt = slope_mv(3'(xcode - 2'h1));
        end else if (!i_fast_transient && i_phase_count == PHASES_TWO && i_cfg[TWO_PH_BIT]) begin
            slope_nxt = SLOPE_TWO_PH_MV;
        end else if (!i_fast_transient && i_phase_count == PHASES_ONE && i_cfg[ONE_PH_BIT]) begin
            slope_nxt = SLOPE_ONE_PH_MV;
        end
    end

    // output registers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            shed_en_r <= 1'b0;
            thresh_r <= 6'h00;
            drop_r <= 1'b0;
            slope_r <= 9'h000;
        end else begin
            shed_en_r <= shed_en_nxt;
            thresh_r <= thresh_nxt;
            drop_r <= drop_nxt;
            slope_r <= slope_nxt;
        end
    end

    assign o_shed_enable = shed_en_r;
    assign o_drop_threshold = thresh_r;
    assign o_drop_request = drop_r;
    assign o_slope_mv = slope_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_no_drop_disabled: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_cfg[SHED_EN_BIT] |=> !o_drop_request)
        else $error("drop requested while shedding disabled");

    a_one_phase_slope: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (!i_fast_transient && i_phase_count == PHASES_ONE && i_cfg[ONE_PH_BIT])
        |=> o_slope_mv == 9'h050)
        else $error("one-phase slope not 80 mV");

    a_transient_slope: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_fast_transient && i_cfg[XSLOPE_HI:XSLOPE_LO] == 2'h3) |=> o_slope_mv == 9'h078)
        else $error("transient slope not 120 mV");

    a_drop_threshold_min: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_peak_sel == 2'h0 && i_cfg[DROP_OFS_HI:DROP_OFS_LO] == 2'h0) |=> o_drop_threshold == 6'h16)
        else $error("3-to-2 threshold not 22 A");

    a_base_slope_max: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (!i_fast_transient && i_phase_count == PHASES_THREE && i_cfg[BASE_HI:BASE_LO] == 3'h7)
        |=> o_slope_mv == 9'h140)
        else $error("base slope 111b not 320 mV");

endmodule : channel_slope_shed

// File: design/phase_shed_slope_config.sv
`timescale 1ns/1ps

module phase_shed_slope_config
    import phase_shed_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [15:0] i_nvm_word_a,
    input wire logic [15:0] i_nvm_word_b,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic i_req_word,
    input wire logic [7:0] i_req_code,
    input wire logic [7:0] i_page,
    input wire logic [15:0] i_wr_data,
    input wire logic [1:0] i_peak_sel_a,
    input wire logic [1:0] i_peak_sel_b,
    input wire logic [7:0] i_avg_current_a,
    input wire logic [7:0] i_avg_current_b,
    input wire logic [1:0] i_phase_count_a,
    input wire logic [1:0] i_phase_count_b,
    input wire logic i_fast_transient_a,
    input wire logic i_fast_transient_b,
    output logic [15:0] o_rd_data,
    output logic o_ack,
    output logic o_nack,
    output logic o_shed_enable_a,
    output logic o_shed_enable_b,
    output logic [5:0] o_drop_threshold_a,
    output logic [5:0] o_drop_threshold_b,
    output logic o_drop_request_a,
    output logic o_drop_request_b,
    output logic [8:0] o_slope_mv_a,
    output logic [8:0] o_slope_mv_b
);

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    logic page_ok;
    logic hit;
    logic page_idx;

    // only the two documented pages are valid
    assign page_ok = (i_page == PAGE_CH_A) || (i_page == PAGE_CH_B);
    // word transfer of the right command on a valid page
    assign hit = i_req_valid && i_req_word && (i_req_code == CMD_SLOPE_CONFIG) && page_ok;
    assign page_idx = (i_page == PAGE_CH_B);

    logic wr_hit;
    logic rd_hit;
    logic refused;

    // accepted writes and reads, and requests answered with a refusal
    assign wr_hit = hit && i_req_write;
    assign rd_hit = hit && !i_req_write;
    assign refused = i_req_valid && !hit;

    // ----------------------------------------------------------------
    // register storage and answer
    // ----------------------------------------------------------------
    logic [15:0] regs_r [NUM_PAGES];
    logic [15:0] regs_nxt [NUM_PAGES];
    logic [15:0] rd_data_r, rd_data_nxt;
    logic ack_r, ack_nxt;
    logic nack_r, nack_nxt;

    // next values of the page copies and of the bus answer
    always_comb begin
        regs_nxt = regs_r;
        rd_data_nxt = rd_data_r;
        ack_nxt = hit;
        nack_nxt = refused;
        if (i_rst) begin
            regs_nxt[0] = i_nvm_word_a;
            regs_nxt[1] = i_nvm_word_b;
            rd_data_nxt = 16'h0000;
            ack_nxt = 1'b0;
            nack_nxt = 1'b0;
        end else if (wr_hit) begin
            regs_nxt[page_idx] = i_wr_data; // all sixteen bits
        end else if (rd_hit) begin
            rd_data_nxt = regs_r[page_idx];
        end
    end

    // registers; reset contents come from the non-volatile image
    always_ff @(posedge i_ref_clk) begin
        regs_r <= regs_nxt;
        rd_data_r <= rd_data_nxt;
        ack_r <= ack_nxt;
        nack_r <= nack_nxt;
    end

    assign o_rd_data = rd_data_r;
    assign o_ack = ack_r;
    assign o_nack = nack_r;

    // ----------------------------------------------------------------
    // per-channel decode of the stored word
    // ----------------------------------------------------------------
    channel_slope_shed u_chan_a (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_cfg(regs_r[0]),
        .i_peak_sel(i_peak_sel_a),
        .i_avg_current(i_avg_current_a),
        .i_phase_count(i_phase_count_a),
        .i_fast_transient(i_fast_transient_a),
        .o_shed_enable(o_shed_enable_a),
        .o_drop_threshold(o_drop_threshold_a),
        .o_drop_request(o_drop_request_a),
        .o_slope_mv(o_slope_mv_a)
    );

    channel_slope_shed u_chan_b (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_cfg(regs_r[1]),
        .i_peak_sel(i_peak_sel_b),
        .i_avg_current(i_avg_current_b),
        .i_phase_count(i_phase_count_b),
        .i_fast_transient(i_fast_transient_b),
        .o_shed_enable(o_shed_enable_b),
        .o_drop_threshold(o_drop_threshold_b),
        .o_drop_request(o_drop_request_b),
        .o_slope_mv(o_slope_mv_b)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_write_a;
        hit && i_req_write && i_page == 8'h00;
    endsequence

    sequence s_write_b;
        hit && i_req_write && i_page == 8'h01;
    endsequence

    sequence s_read_a;
        rd_hit && i_page == 8'h00;
    endsequence

    sequence s_read_b;
        rd_hit && i_page == 8'h01;
    endsequence

    sequence s_refused;
        refused;
    endsequence

    a_write_page_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_a |=> regs_r[0] == $past(i_wr_data) && regs_r[1] == $past(regs_r[1]))
        else $error("page 00h write did not land in channel A only");

    a_write_page_b: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_b |=> regs_r[1] == $past(i_wr_data) && regs_r[0] == $past(regs_r[0]))
        else $error("page 01h write did not land in channel B only");

    a_write_then_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (s_write_a ##1 s_read_a)
        |=> o_rd_data == $past(i_wr_data, 2))
        else $error("read back differs from the word written");

    a_read_answer: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (hit && !i_req_write) |=> o_ack && o_rd_data == $past(regs_r[page_idx]))
        else $error("word read did not return the stored word");

    a_wrong_code: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_req_valid && i_req_code != 8'hde) |=> o_nack && !o_ack)
        else $error("foreign command code was accepted");

    a_byte_refused: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_req_valid && !i_req_word && i_req_write) |=> o_nack && $stable(regs_r[0]) && $stable(regs_r[1]))
        else $error("non-word write changed the register");

    a_bad_page: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_req_valid && i_page > 8'h01) |=> o_nack)
        else $error("access on an unknown page was accepted");

    a_reset_load: assert property (@(posedge i_ref_clk)
        i_rst |=> regs_r[0] == $past(i_nvm_word_a) && regs_r[1] == $past(i_nvm_word_b))
        else $error("reset did not load the non-volatile image");

    a_idle_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_req_valid |=> !o_ack && !o_nack)
        else $error("answer without a request");

    a_read_page_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_read_a
        |=> o_rd_data == $past(regs_r[0]))
        else $error("page 00h read did not return channel A copy");

    a_read_page_b: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_read_b
        |=> o_rd_data == $past(regs_r[1]))
        else $error("page 01h read did not return channel B copy");

    a_read_keeps_regs: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        rd_hit
        |=> $stable(regs_r[0]) && $stable(regs_r[1]))
        else $error("a read changed a page copy");

    a_refused_keeps_regs: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_refused
        |=> $stable(regs_r[0]) && $stable(regs_r[1]))
        else $error("a refused request changed a page copy");

    a_refused_keeps_data: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_refused
        |=> $stable(o_rd_data))
        else $error("a refused request changed the read data");

    a_write_keeps_data: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_hit
        |=> $stable(o_rd_data))
        else $error("a write changed the read data");

    a_idle_keeps_regs: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_req_valid
        |=> $stable(regs_r[0]) && $stable(regs_r[1]))
        else $error("a page copy changed without a request");

    a_accept_acked: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        hit
        |=> o_ack && !o_nack)
        else $error("an accepted request was not acknowledged");

    a_upper_bits_kept: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_write_b
        |=> regs_r[1][UNUSED_HI:UNUSED_LO] == $past(i_wr_data[UNUSED_HI:UNUSED_LO]))
        else $error("upper bits of a write were not stored");

    a_byte_read_refused: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_req_valid && !i_req_word && !i_req_write)
        |=> o_nack && $stable(o_rd_data))
        else $error("a non-word read was answered");

    a_reset_answer: assert property (@(posedge i_ref_clk)
        i_rst
        |=> !o_ack && !o_nack && o_rd_data == 16'h0000)
        else $error("bus answer not cleared by reset");

    // ----------------------------------------------------------------
    // checks of the per-channel routing
    // ----------------------------------------------------------------
    a_route_shed_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !$past(i_rst)
        |-> o_shed_enable_a == $past(regs_r[0][SHED_EN_BIT]))
        else $error("channel A enable not taken from page 00h");

    a_route_shed_b: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !$past(i_rst)
        |-> o_shed_enable_b == $past(regs_r[1][SHED_EN_BIT]))
        else $error("channel B enable not taken from page 01h");

    a_peak_max_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_peak_sel_a == 2'h3 && regs_r[0][DROP_OFS_HI:DROP_OFS_LO] == 2'h3)
        |=> o_drop_threshold_a == 6'h28)
        else $error("channel A threshold not 40 A at 18 A peak");

    a_peak_low_b: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_peak_sel_b == 2'h1 && regs_r[1][DROP_OFS_HI:DROP_OFS_LO] == 2'h1)
        |=> o_drop_threshold_b == 6'h1c)
        else $error("channel B threshold not 28 A at 14 A peak");

    a_drop_three_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_phase_count_a != PHASES_THREE
        |=> !o_drop_request_a)
        else $error("channel A drop requested below three phases");

    a_drop_three_b: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_phase_count_b != PHASES_THREE
        |=> !o_drop_request_b)
        else $error("channel B drop requested below three phases");

    a_drop_reach_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (regs_r[0][SHED_EN_BIT] && i_phase_count_a == PHASES_THREE
        && i_avg_current_a == {2'h0, drop_threshold(i_peak_sel_a, regs_r[0][DROP_OFS_HI:DROP_OFS_LO])})
        |=> o_drop_request_a)
        else $error("no channel A drop with current at the threshold");

    a_drop_above_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_avg_current_a == 8'({2'h0, drop_threshold(i_peak_sel_a, regs_r[0][DROP_OFS_HI:DROP_OFS_LO])} + 8'h01))
        |=> !o_drop_request_a)
        else $error("channel A drop with current above the threshold");

    a_drop_reach_b: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (regs_r[1][SHED_EN_BIT] && i_phase_count_b == PHASES_THREE
        && i_avg_current_b == {2'h0, drop_threshold(i_peak_sel_b, regs_r[1][DROP_OFS_HI:DROP_OFS_LO])})
        |=> o_drop_request_b)
        else $error("no channel B drop with current at the threshold");

    a_base_slope_min_b: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (!i_fast_transient_b && i_phase_count_b == PHASES_THREE && regs_r[1][BASE_HI:BASE_LO] == 3'h0)
        |=> o_slope_mv_b == 9'h028)
        else $error("channel B base slope 000b not 40 mV");

endmodule : phase_shed_slope_config

// File: dv/host_word_master.sv
`timescale 1ns/1ps

module host_word_master (
    input wire logic i_ref_clk,
    input wire logic i_ack,
    input wire logic i_nack,
    input wire logic [15:0] i_rd_data,
    output logic o_req_valid,
    output logic o_req_write,
    output logic o_req_word,
    output logic [7:0] o_req_code,
    output logic [7:0] o_page,
    output logic [15:0] o_wr_data
);
    // ----------------------------------------
    // host side of the word transfer port
    // ----------------------------------------
    // idle bus, no request pending
    initial begin
        o_req_valid = 1'b0;
        o_req_write = 1'b0;
        o_req_word = 1'b0;
        o_req_code = 8'h00;
        o_page = 8'h00;
        o_wr_data = 16'h0000;
    end

    // one request cycle, answer taken 1 ns after the taking edge
    task automatic xfer(input logic wr, input logic word, input logic [7:0] code,
                        input logic [7:0] page, input logic [15:0] data,
                        output logic ack, output logic nack, output logic [15:0] rdata);
        @(posedge i_ref_clk);
        o_req_valid <= 1'b1;
        o_req_write <= wr;
        o_req_word <= word;
        o_req_code <= code;
        o_page <= page;
        o_wr_data <= data; // whole word
        @(posedge i_ref_clk);
        o_req_valid <= 1'b0;
        // released qualifiers stop showing the last value
        o_req_code <= ~code;
        o_page <= ~page;
        o_wr_data <= ~data;
        #1;
        ack = i_ack;
        nack = i_nack;
        rdata = i_rd_data;
    endtask : xfer

    // word write, then a word read of the same page in the very next cycle
    task automatic write_read(input logic [7:0] code, input logic [7:0] page, input logic [15:0] data,
                              output logic wr_ack, output logic rd_ack, output logic [15:0] rdata);
        @(posedge i_ref_clk);
        o_req_valid <= 1'b1;
        o_req_write <= 1'b1;
        o_req_word <= 1'b1;
        o_req_code <= code;
        o_page <= page;
        o_wr_data <= data;
        @(posedge i_ref_clk);
        o_req_write <= 1'b0;
        #1;
        wr_ack = i_ack;
        @(posedge i_ref_clk);
        o_req_valid <= 1'b0;
        o_req_code <= ~code;
        o_page <= ~page;
        o_wr_data <= ~data;
        #1;
        rd_ack = i_ack;
        rdata = i_rd_data;
    endtask : write_read
endmodule : host_word_master

// File: dv/tb_phase_shed_slope_config.sv
`timescale 1ns/1ps

module tb_phase_shed_slope_config;
    import phase_shed_pkg::*;

    logic i_ref_clk;
    logic i_rst;
    logic [15:0] nvm [2];
    logic [1:0] peak_sel [2];
    logic [7:0] avg [2];
    logic [1:0] phases [2];
    logic fast [2];
    logic shed_en [2];
    logic [5:0] drop_thr [2];
    logic drop_req [2];
    logic [8:0] slope [2];
    logic req_valid, req_write, req_word, ack, nack;
    logic got_ack, got_nack, got_rd_ack;
    logic [7:0] req_code, page;
    logic [15:0] wr_data, rd_data, last_rd, w, rdv;
    logic [15:0] model [2];
    logic [31:0] seed = 32'h0000005c;
    logic [31:0] r;
    logic [5:0] thr;
    int fails = 0;
    int tests_run = 0;

    host_word_master u_host_word_master (.i_ref_clk(i_ref_clk), .i_ack(ack), .i_nack(nack),
        .i_rd_data(rd_data), .o_req_valid(req_valid), .o_req_write(req_write), .o_req_word(req_word),
        .o_req_code(req_code), .o_page(page), .o_wr_data(wr_data));

    phase_shed_slope_config u_phase_shed_slope_config (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_nvm_word_a(nvm[0]), .i_nvm_word_b(nvm[1]), .i_req_valid(req_valid), .i_req_write(req_write),
        .i_req_word(req_word), .i_req_code(req_code), .i_page(page), .i_wr_data(wr_data),
        .i_peak_sel_a(peak_sel[0]), .i_peak_sel_b(peak_sel[1]), .i_avg_current_a(avg[0]),
        .i_avg_current_b(avg[1]), .i_phase_count_a(phases[0]), .i_phase_count_b(phases[1]),
        .i_fast_transient_a(fast[0]), .i_fast_transient_b(fast[1]), .o_rd_data(rd_data), .o_ack(ack),
        .o_nack(nack), .o_shed_enable_a(shed_en[0]), .o_shed_enable_b(shed_en[1]),
        .o_drop_threshold_a(drop_thr[0]), .o_drop_threshold_b(drop_thr[1]),
        .o_drop_request_a(drop_req[0]), .o_drop_request_b(drop_req[1]),
        .o_slope_mv_a(slope[0]), .o_slope_mv_b(slope[1]));

    // ----------------------------------------
    // expectation helpers
    // ----------------------------------------
    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : next_rand

    // twice 12..18 A, then -2, 0, +2 or +4 A
    function automatic logic [5:0] exp_thr(input logic [1:0] sel, input logic [1:0] ofs);
        return 6'(6'h16 + 6'h04 * 6'(sel) + 6'h02 * 6'(ofs));
    endfunction : exp_thr

    // fast transient first, then two-phase, then one-phase, else base; transient code 00b keeps base
    function automatic logic [8:0] exp_slope(input logic [15:0] v, input logic [1:0] ph, input logic ft);
        if (ft && v[6:5] != 2'h0) return 9'(9'h028 * 9'(v[6:5]));
        if (!ft && ph == 2'h2 && v[4]) return 9'h078;
        if (!ft && ph == 2'h1 && v[3]) return 9'h050;
        return 9'(9'h028 * (9'(v[2:0]) + 9'h001));
    endfunction : exp_slope

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        if (fails == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // one access with the expected answer worked out from the shadow copies
    task automatic access(input logic wr, input logic wd, input logic [7:0] code,
                          input logic [7:0] pg, input logic [15:0] data);
        logic hit;
        hit = wd && code == CMD_SLOPE_CONFIG && pg <= PAGE_CH_B;
        u_host_word_master.xfer(wr, wd, code, pg, data, got_ack, got_nack, rdv);
        if (hit && !wr) last_rd = model[pg[0]];
        if (hit && wr) model[pg[0]] = data;
        check(16'(got_ack), 16'(hit));
        check(16'(got_nack), 16'(!hit));
        check(rdv, last_rd);
    endtask : access

    task automatic check_ch(input int c);
        w = model[c];
        thr = exp_thr(peak_sel[c], w[9:8]);
        check(16'(shed_en[c]), 16'(w[7]));
        check(16'(drop_thr[c]), 16'(thr));
        check(16'(drop_req[c]), 16'(w[7] && phases[c] == 2'h3 && avg[c] <= 8'(thr)));
        check(16'(slope[c]), 16'(exp_slope(w, phases[c], fast[c])));
    endtask : check_ch

    // ----------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        fails++;
        print_verdict();
    end

    initial begin
        i_rst <= 1'b1;
        nvm[0] <= 16'ha5b3;
        nvm[1] <= 16'h1e4c;
        for (int c = 0; c < 2; c++) begin
            peak_sel[c] <= 2'(c);
            avg[c] <= 8'h10;
            phases[c] <= 2'h3;
            fast[c] <= 1'b0;
        end
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        model[0] = 16'ha5b3;
        model[1] = 16'h1e4c;
        last_rd = 16'h0000;
        repeat (2) @(posedge i_ref_clk);
        #1;
        check_ch(0);
        check_ch(1);
        access(1'b0, 1'b1, CMD_SLOPE_CONFIG, PAGE_CH_A, 16'h0000);
        access(1'b0, 1'b1, CMD_SLOPE_CONFIG, PAGE_CH_B, 16'h0000);
        // refused: byte size, foreign code, foreign page
        access(1'b1, 1'b0, CMD_SLOPE_CONFIG, PAGE_CH_A, 16'hffff);
        access(1'b1, 1'b1, 8'hdf, PAGE_CH_A, 16'hffff);
        access(1'b1, 1'b1, CMD_SLOPE_CONFIG, 8'h02, 16'hffff);
        access(1'b0, 1'b0, CMD_SLOPE_CONFIG, PAGE_CH_B, 16'h0000);
        access(1'b0, 1'b1, CMD_SLOPE_CONFIG, PAGE_CH_A, 16'h0000);
        // a read in the cycle right after a write sees the new word
        u_host_word_master.write_read(CMD_SLOPE_CONFIG, PAGE_CH_A, 16'h3c96, got_ack, got_rd_ack, rdv);
        model[0] = 16'h3c96;
        last_rd = 16'h3c96;
        check(16'(got_ack), 16'h0001);
        check(16'(got_rd_ack), 16'h0001);
        check(rdv, last_rd);
        // random words and channel conditions, threshold edge included
        for (int i = 0; i < 80; i++) begin
            r = next_rand();
            access(1'b1, 1'b1, CMD_SLOPE_CONFIG, {7'h00, r[0]}, r[31:16]);
            @(posedge i_ref_clk);
            for (int c = 0; c < 2; c++) begin
                r = next_rand();
                peak_sel[c] <= r[1:0];
                phases[c] <= 2'(2'h1 + 2'(r[7:4] % 4'h3));
                fast[c] <= r[8];
                avg[c] <= 8'(exp_thr(r[1:0], model[c][9:8])) + 8'(r[11:10]) - 8'h01;
            end
            repeat (2) @(posedge i_ref_clk);
            #1;
            check_ch(0);
            check_ch(1);
            access(1'b0, 1'b1, CMD_SLOPE_CONFIG, {7'h00, r[3]}, 16'h0000);
        end
        print_verdict();
    end
endmodule : tb_phase_shed_slope_config
